// *** include/sspc_pkg.sv ***
// Constants and types shared by the sleep, power and start-up controller
package sspc_pkg;
  // Register map (byte addresses on the AXI4-Lite bus)
  localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
  localparam logic [3:0] REG_STAT_ADDR = 4'h4;
  localparam int         ADDR_LSB      = 2;
  // Control register fields
  localparam int         BIT_SWDT      = 0;
  localparam int         BIT_SINK      = 1;
  localparam int         BIT_WAKE_EN   = 2;
  localparam int         BIT_RET       = 4;
  localparam int         BIT_LVL       = 5;
  localparam int         BIT_REGULATOR_SLEEP_LOWPOWER    = 7;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h97;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  // Status register fields
  localparam int         ST_PRI        = 0;
  localparam int         ST_WDT        = 1;
  localparam int         ST_REC        = 2;
  localparam int         ST_MODE_LO    = 3;
  localparam int         ST_STRAP      = 5;
  // Watchdog mode configuration codes
  localparam logic [1:0] WDT_MODE_OFF  = 2'h0;
  localparam logic [1:0] WDT_MODE_SW   = 2'h1;
  localparam logic [1:0] WDT_MODE_RUN  = 2'h2;
  localparam logic [1:0] WDT_MODE_ON   = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Timing
  localparam int         CLK_MHZ       = 125;
  localparam int         REC_TIME_US   = 250;
  localparam int         REC_CYCLES    = REC_TIME_US * CLK_MHZ;
  localparam int         REC_W         = 16;
  localparam logic [1:0] SWITCH_GAP    = 2'h2;
  // Number of synchronised pin inputs
  localparam int         NSYNC         = 10;

  typedef enum logic [1:0] {
    REG_NORMAL,
    REG_LOWPOWER,
    REG_ULTRA
  } sspc_reg_mode_t;

  typedef enum logic [2:0] {
    SQ_PWRT,
    SQ_OST,
    SQ_RUN,
    SQ_SLEEP,
    SQ_RECOVER
  } sspc_seq_t;
endpackage : sspc_pkg

// *** include/sspc_clk_if.sv ***
// Core clock switch handshake between sequencer and clock gate logic
`timescale 1ns/100ps
interface sspc_clk_if;
  logic req_primary;
  logic gate_internal;
  logic gate_primary;

  modport ctl (output req_primary, input gate_internal, input gate_primary);
  modport sw  (input req_primary, output gate_internal, output gate_primary);
endinterface : sspc_clk_if

// *** core/sspc_clk_switch.sv ***
// Break-before-make switch between internal and primary core clocks
`timescale 1ns/100ps
module sspc_clk_switch
  import sspc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  sspc_clk_if.sw   sw
);
  logic       gate_int;
  logic       gate_pri;
  logic [1:0] gap;

  // Both gates closed for a settle gap, so no short phase reaches the core
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_int <= 1'b1;
      gate_pri <= 1'b0;
      gap      <= 2'h0;
    end else if (gate_pri != sw.req_primary ||
                 gate_int == sw.req_primary) begin
      if (gate_int || gate_pri) begin
        gate_int <= 1'b0;
        gate_pri <= 1'b0;
        gap      <= SWITCH_GAP;
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else begin
        gate_pri <= sw.req_primary;
        gate_int <= ~sw.req_primary;
      end
    end
  end

  assign sw.gate_internal = gate_int;
  assign sw.gate_primary  = gate_pri;
endmodule : sspc_clk_switch

// *** core/sspc_ctrl.sv ***
// Sleep, regulator, watchdog enable and two-speed start-up controller
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module sspc_ctrl
  import sspc_pkg::*;
#(
  parameter int REC_CYC = REC_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pins, configuration and partner status
  input  wire logic        regulator_enable_strap,
  input  wire logic        wake_comparator_in,
  input  wire logic        power_up_timer_done,
  input  wire logic        osc_startup_timer_done,
  input  wire logic        cfg_retention_disable_n,
  input  wire logic        two_speed_startup_enable,
  input  wire logic [1:0]  cfg_watchdog_mode,
  input  wire logic        brownout_reset_enable,
  input  wire logic        low_voltage_detect_enable,
  // Core side, same clock
  input  wire logic        sleep_active,
  input  wire logic        wake_event,
  input  wire logic        ref_wake_event,
  input  wire logic        pm_alt_mode,
  input  wire logic        pm_sel_internal,
  input  wire logic        sleep_exec,
  input  wire logic        clrwdt_exec,
  input  wire logic [2:0]  internal_osc_freq_select,
  // Outputs
  output logic             core_clk_internal_gate,
  output logic             core_clk_primary_gate,
  output logic             core_run_enable,
  output logic             primary_osc_enable,
  output logic             regulator_enable,
  output logic [1:0]       regulator_sleep_mode,
  output logic             references_on,
  output logic             watchdog_enable,
  output logic             watchdog_clear,
  output logic             wake_module_on,
  output logic             wake_sink_on
);
  // Pin synchronisers; first stage feeds only the second
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic             strap;
  logic             comp;
  logic             pwrt_done;
  logic             ost_done;
  logic             ret_dis_n;
  logic             two_speed;
  logic [1:0]       wdt_mode;
  logic             bor_en;
  logic             lvd_en;

  logic [7:0]       ctrl;
  logic             aw_hold;
  logic             w_hold;
  logic [3:0]       aw_addr;
  logic [7:0]       w_data;
  logic             w_lane0;
  logic             ret_avail;
  logic [7:0]       ctrl_view;
  logic [7:0]       stat_view;

  sspc_seq_t        seq;
  sspc_seq_t        next_seq;
  logic [REC_W-1:0] rec_cnt;
  logic             use_internal;
  logic             ulp_mode;
  logic             refs_keep;
  logic             woke;
  sspc_reg_mode_t   sel_mode;
  logic [2:0]       freq_q;

  sspc_clk_if       clk_link ();

  function automatic logic addr_is(input logic [3:0] a,
                                   input logic [3:0] target);
    addr_is = a[3:ADDR_LSB] == target[3:ADDR_LSB];
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = addr_is(a, REG_CTRL_ADDR) || addr_is(a, REG_STAT_ADDR);
  endfunction : addr_mapped

  // Static fuses are synchronised too; costs two cycles, avoids hazards
  always_ff @(posedge clk_sys) begin
    sync_a <= {lvd_in_pack(low_voltage_detect_enable,
                           brownout_reset_enable),
               cfg_watchdog_mode, two_speed_startup_enable,
               cfg_retention_disable_n, osc_startup_timer_done,
               power_up_timer_done, wake_comparator_in,
               regulator_enable_strap};
    sync_b <= sync_a;
  end

  function automatic logic [1:0] lvd_in_pack(input logic l,
                                             input logic b);
    lvd_in_pack = {l, b};
  endfunction : lvd_in_pack

  assign strap     = sync_b[0];
  assign comp      = sync_b[1];
  assign pwrt_done = sync_b[2];
  assign ost_done  = sync_b[3];
  assign ret_dis_n = sync_b[4];
  assign two_speed = sync_b[5];
  assign wdt_mode  = sync_b[7:6];
  assign bor_en    = sync_b[8];
  assign lvd_en    = sync_b[9];

  // Retention select bit only exists for this strap and fuse setting
  assign ret_avail = strap & ~ret_dis_n;

  // Write address and data accepted in either order
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_hold <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (aw_hold && w_hold) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_hold  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold  <= 1'b1;
      w_data  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (aw_hold && w_hold) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_hold && w_hold) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; unimplemented bits never store
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else begin
      if (aw_hold && w_hold && w_lane0 &&
          addr_is(aw_addr, REG_CTRL_ADDR)) begin
        ctrl <= w_data & CTRL_WR_MASK;
      end
      if (!ret_avail) begin
        ctrl[BIT_RET] <= 1'b0;
      end
    end
  end

  // Comparator level is live, not stored, so reads follow the pin
  always_comb begin
    ctrl_view          = ctrl;
    ctrl_view[BIT_LVL] = comp;
  end

  always_comb begin
    stat_view                      = 8'h00;
    stat_view[ST_PRI]              = core_clk_primary_gate;
    stat_view[ST_WDT]              = watchdog_enable;
    stat_view[ST_REC]              = seq == SQ_RECOVER;
    stat_view[ST_MODE_LO +: 2]     = sel_mode;
    stat_view[ST_STRAP]            = strap;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_is(s_axi_araddr, REG_CTRL_ADDR)) begin
        s_axi_rdata <= {24'h0, ctrl_view};
      end else if (addr_is(s_axi_araddr, REG_STAT_ADDR)) begin
        s_axi_rdata <= {24'h0, stat_view};
      end else begin
        s_axi_rdata <= 32'h0;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Regulator mode to apply in Sleep
  always_comb begin
    if (ctrl[BIT_RET] && ret_avail) begin
      sel_mode = REG_ULTRA;
    end else if (ctrl[BIT_REGULATOR_SLEEP_LOWPOWER]) begin
      sel_mode = REG_LOWPOWER;
    end else begin
      sel_mode = REG_NORMAL;
    end
  end

  assign ulp_mode = sel_mode == REG_ULTRA;
  assign refs_keep = !(seq == SQ_SLEEP && ulp_mode) || bor_en || lvd_en;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regulator_enable     <= 1'b0;
      regulator_sleep_mode <= REG_NORMAL;
      references_on        <= 1'b1;
    end else begin
      regulator_enable     <= strap;
      regulator_sleep_mode <= (seq == SQ_SLEEP && strap) ?
                              sel_mode : REG_NORMAL;
      references_on        <= refs_keep;
    end
  end

  // Live decision: the registered reference output lags Sleep entry
  assign woke = wake_event || (ref_wake_event && refs_keep);

  // Wake-up module and sink
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_module_on <= 1'b0;
      wake_sink_on   <= 1'b0;
    end else begin
      wake_module_on <= ctrl[BIT_WAKE_EN];
      wake_sink_on   <= ctrl[BIT_SINK] & ctrl[BIT_WAKE_EN];
    end
  end

  // Watchdog enable and clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_enable <= 1'b0;
      watchdog_clear  <= 1'b0;
      freq_q          <= 3'h0;
    end else begin
      freq_q <= internal_osc_freq_select;
      unique case (wdt_mode)
        WDT_MODE_ON:  watchdog_enable <= 1'b1;
        WDT_MODE_RUN: watchdog_enable <= seq != SQ_SLEEP;
        WDT_MODE_SW:  watchdog_enable <= ctrl[BIT_SWDT];
        WDT_MODE_OFF: watchdog_enable <= ctrl[BIT_SWDT];
      endcase
      watchdog_clear <= (freq_q != internal_osc_freq_select) ||
                        sleep_exec || clrwdt_exec;
    end
  end

  // Start-up sequencer
  assign use_internal = pm_alt_mode ? pm_sel_internal :
                        two_speed;

  always_comb begin
    next_seq = seq;
    unique case (seq)
      SQ_PWRT:    if (pwrt_done) next_seq = SQ_OST;
      SQ_OST: begin
        if (sleep_active) begin
          next_seq = SQ_SLEEP;
        end else if (ost_done) begin
          next_seq = SQ_RUN;
        end
      end
      SQ_RUN:     if (sleep_active) next_seq = SQ_SLEEP;
      SQ_SLEEP: begin
        if (woke) begin
          next_seq = ulp_mode ? SQ_RECOVER : SQ_OST;
        end
      end
      SQ_RECOVER: if (rec_cnt == '0) next_seq = SQ_OST;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq <= SQ_PWRT;
    end else begin
      seq <= next_seq;
    end
  end

  // Regulator recovery delay after ultra low-power Sleep
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rec_cnt <= '0;
    end else if (seq == SQ_SLEEP) begin
      rec_cnt <= REC_W'(REC_CYC - 1);
    end else if (seq == SQ_RECOVER && rec_cnt != '0) begin
      rec_cnt <= rec_cnt - 1'b1;
    end
  end

  // Primary request only in run mode; internal clock covers OSC_STARTUP_TIMER
  assign clk_link.req_primary = seq == SQ_RUN;

  sspc_clk_switch u_switch (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sw      (clk_link.sw)
  );

  assign core_clk_internal_gate = clk_link.gate_internal;
  assign core_clk_primary_gate  = clk_link.gate_primary;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      core_run_enable    <= 1'b0;
      primary_osc_enable <= 1'b0;
    end else begin
      primary_osc_enable <= next_seq != SQ_SLEEP &&
                            next_seq != SQ_RECOVER;
      core_run_enable    <= (seq == SQ_RUN && clk_link.gate_primary) ||
                            (seq == SQ_OST && use_internal &&
                             clk_link.gate_internal);
    end
  end
endmodule : sspc_ctrl

// *** tb/sspc_ctrl_props.sv ***
// Port-level assertions for the sleep, power and start-up controller
`timescale 1ns/100ps
module sspc_ctrl_props
  import sspc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       regulator_enable_strap,
  input wire logic       brownout_reset_enable,
  input wire logic [1:0] cfg_watchdog_mode,
  input wire logic       sleep_exec,
  input wire logic       clrwdt_exec,
  input wire logic [2:0] internal_osc_freq_select,
  input wire logic       core_clk_internal_gate,
  input wire logic       core_clk_primary_gate,
  input wire logic       core_run_enable,
  input wire logic       regulator_enable,
  input wire logic [1:0] regulator_sleep_mode,
  input wire logic       references_on,
  input wire logic       watchdog_enable,
  input wire logic       watchdog_clear,
  input wire logic       wake_module_on,
  input wire logic       wake_sink_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_one_gate; !(core_clk_internal_gate && core_clk_primary_gate);
  endproperty
  a_one_gate: assert property (p_one_gate)
    else $error("Both core clock gates open");
  // Gap keeps the core from seeing a short phase during the swap
  property p_gap;
    $fell(core_clk_internal_gate) |-> (!core_clk_primary_gate)[*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("Primary gate opened without a gap");
  property p_strap;
    $stable(regulator_enable_strap)[*5] |-> 
      regulator_enable == regulator_enable_strap;
  endproperty
  a_strap: assert property (p_strap)
    else $error("Regulator enable does not follow the strap");
  property p_mode_strap;
    regulator_sleep_mode != REG_NORMAL |-> regulator_enable;
  endproperty
  a_mode_strap: assert property (p_mode_strap)
    else $error("Sleep regulator mode set with regulator off");
  property p_wdt_on;
    (cfg_watchdog_mode == WDT_MODE_ON)[*5] |-> watchdog_enable;
  endproperty
  a_wdt_on: assert property (p_wdt_on)
    else $error("Watchdog off although configuration enables it");
  property p_clr_ins; sleep_exec || clrwdt_exec |-> ##[1:3] watchdog_clear;
  endproperty
  a_clr_ins: assert property (p_clr_ins)
    else $error("No watchdog clear after instruction");
  property p_clr_frq;
    $changed(internal_osc_freq_select) |-> ##[1:3] watchdog_clear;
  endproperty
  a_clr_frq: assert property (p_clr_frq)
    else $error("No watchdog clear after frequency change");
  property p_sink; wake_sink_on |-> wake_module_on;
  endproperty
  a_sink: assert property (p_sink)
    else $error("Current sink on without wake module");
  property p_run;
    $rose(core_run_enable) |->
      $past(core_clk_internal_gate || core_clk_primary_gate);
  endproperty
  a_run: assert property (p_run)
    else $error("Core started with no clock gate open");
  property p_refs; brownout_reset_enable[*5] |-> references_on;
  endproperty
  a_refs: assert property (p_refs)
    else $error("References off while brown-out reset enabled");
endmodule : sspc_ctrl_props

bind sspc_ctrl sspc_ctrl_props i_props (.*);

// *** tb/sspc_osc_model.sv ***
// Behavioural power-up timer and crystal start-up timer
`timescale 1ns/100ps
module sspc_osc_model #(
  parameter int PWRT_CYC = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       primary_osc_enable,
  input  wire logic [7:0] ost_cyc,
  output logic            power_up_timer_done,
  output logic            osc_startup_timer_done
);
  int pwrt_cnt;
  int ost_cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwrt_cnt <= 0;
      power_up_timer_done <= 1'b0;
    end else if (pwrt_cnt < PWRT_CYC) begin
      pwrt_cnt <= pwrt_cnt + 1;
    end else begin
      power_up_timer_done <= 1'b1;
    end
  end
  // A stopped crystal must settle again from scratch
  always_ff @(posedge clk_sys) begin
    if (rst || !primary_osc_enable) begin
      ost_cnt <= 0;
      osc_startup_timer_done <= 1'b0;
    end else if (ost_cnt < int'(ost_cyc)) begin
      ost_cnt <= ost_cnt + 1;
    end else begin
      osc_startup_timer_done <= 1'b1;
    end
  end
endmodule : sspc_osc_model

// *** tb/sleep_power_and_startup_ctrl_bench.sv ***
// Self-checking bench for the sleep, power and start-up controller
`timescale 1ns/100ps
module sleep_power_and_startup_ctrl_bench
  import sspc_pkg::*;
;
  localparam int REC = 20;
  localparam logic [7:0] SLP_CTL [5] = '{8'h00, 8'h80, 8'h90, 8'h00, 8'h00};
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cfg_watchdog_mode;
  logic [1:0]  regulator_sleep_mode;
  logic        regulator_enable_strap, wake_comparator_in, power_up_timer_done;
  logic        osc_startup_timer_done, cfg_retention_disable_n;
  logic        two_speed_startup_enable, brownout_reset_enable;
  logic        low_voltage_detect_enable, sleep_active, wake_event;
  logic        ref_wake_event, pm_alt_mode, pm_sel_internal, sleep_exec;
  logic        clrwdt_exec, core_clk_internal_gate, core_clk_primary_gate;
  logic [2:0]  internal_osc_freq_select;
  logic        core_run_enable, primary_osc_enable, regulator_enable;
  logic        references_on, watchdog_enable, watchdog_clear;
  logic        wake_module_on, wake_sink_on, aw_h, w_h, b_h, ar_h, r_h;
  logic [7:0]  ost_cyc;
  logic [33:0] eq [$];
  logic [33:0] mq [$];
  int          mismatches = 0;
  int          n_compared = 0;

  sspc_ctrl #(.REC_CYC(REC)) i_dut (.*);
  sspc_osc_model i_osc (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    aw_h <= s_axi_awvalid && s_axi_awready;
    w_h  <= s_axi_wvalid && s_axi_wready;
    b_h  <= s_axi_bvalid && s_axi_bready;
    ar_h <= s_axi_arvalid && s_axi_arready;
    r_h  <= s_axi_rvalid && s_axi_rready;
  end
  // Only one transfer is ever open, so one queue pairs all answers
  always @(posedge clk_sys) begin
    if (!rst && s_axi_rvalid && s_axi_rready && eq.size() > 0) begin
      chk({s_axi_rresp, s_axi_rdata} & mq.pop_front(),
          eq.pop_front());
    end
    if (!rst && s_axi_bvalid && s_axi_bready && eq.size() > 0) begin
      chk({s_axi_bresp, 32'h0} & mq.pop_front(), eq.pop_front());
    end
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic [31:0] u;
    u = $urandom();
    eq.push_back({r, 32'h0});
    mq.push_back({2'h3, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {u[31:8], d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(1);
      if (aw_h) s_axi_awvalid <= 1'b0;
      if (w_h) s_axi_wvalid <= 1'b0;
    end while (!b_h);
    s_axi_bready <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r);
    eq.push_back({r, e & m});
    mq.push_back({2'h3, m});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(1);
      if (ar_h) s_axi_arvalid <= 1'b0;
    end while (!r_h);
    s_axi_rready <= 1'b0;
    tick(1);
  endtask : rd
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  initial begin
    int i;
    int n;
    logic [31:0] u;
    logic [7:0] cur;
    logic [7:0] wm;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_wdata, cfg_watchdog_mode, wake_comparator_in} = '0;
    {cfg_retention_disable_n, brownout_reset_enable, pm_alt_mode} = '0;
    {low_voltage_detect_enable, sleep_active, wake_event} = '0;
    {ref_wake_event, pm_sel_internal, sleep_exec, clrwdt_exec} = '0;
    internal_osc_freq_select = 3'h0;
    {rst, two_speed_startup_enable, regulator_enable_strap} = 3'h7;
    ost_cyc = 8'h3c;
    void'($urandom(19));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    // Start-up runs on the internal clock until the crystal is ready
    for (n = 0; n < 60 && core_run_enable !== 1'b1; n++) tick(1);
    chk({core_run_enable, core_clk_internal_gate, core_clk_primary_gate},
        3'h6);
    rd(REG_CTRL_ADDR, 32'h0, 32'hff, RESP_OKAY);
    rd(REG_STAT_ADDR, 32'h0, 32'h1, RESP_OKAY);
    for (n = 0; n < 300 && core_clk_primary_gate !== 1'b1; n++) tick(1);
    tick(2);
    rd(REG_STAT_ADDR, 32'h1, 32'h1, RESP_OKAY);
    cur = 8'h0;
    for (i = 0; i < 16; i++) begin
      u = $urandom();
      regulator_enable_strap    <= u[0];
      cfg_retention_disable_n   <= u[1];
      wake_comparator_in        <= u[2];
      cfg_watchdog_mode         <= 2'(i);
      internal_osc_freq_select  <= u[7:5];
      low_voltage_detect_enable <= u[8];
      clrwdt_exec               <= u[10];
      tick(1);
      clrwdt_exec <= 1'b0;
      tick(5);
      wm = (u[0] && !u[1]) ? CTRL_WR_MASK : (CTRL_WR_MASK & 8'hef);
      cur = (u[9] ? u[23:16] : cur) & wm;
      wr(REG_CTRL_ADDR, u[23:16], {3'h7, u[9]}, RESP_OKAY);
      rd(REG_CTRL_ADDR, {24'h0, cur[7:6], u[2], cur[4:0]}, 32'hff,
         RESP_OKAY);
      rd(REG_STAT_ADDR, {26'h0, u[0], (cur[4] ? 2'h2 : {1'b0, cur[7]}),
         1'b0, i[1] | cur[0], 1'b0}, 32'h3e, RESP_OKAY);
      chk({regulator_enable, wake_module_on, wake_sink_on},
          {u[0], cur[2], cur[2] & cur[1]});
    end
    wr(4'h8, 8'hff, 4'hf, RESP_SLVERR);
    rd(4'h8, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(REG_STAT_ADDR, 8'hff, 4'hf, RESP_OKAY);
    rd(REG_CTRL_ADDR, {24'h0, cur}, 32'hdf, RESP_OKAY);
    regulator_enable_strap    <= 1'b1;
    cfg_retention_disable_n   <= 1'b0;
    cfg_watchdog_mode         <= WDT_MODE_OFF;
    low_voltage_detect_enable <= 1'b0;
    tick(6);
    // Normal, low-power and ultra low-power Sleep, then a single-speed
    // wake and an alternate power-managed mode on the internal source
    for (i = 0; i < 5; i++) begin
      two_speed_startup_enable <= i < 3;
      pm_alt_mode              <= i == 4;
      pm_sel_internal          <= i == 4;
      wr(REG_CTRL_ADDR, SLP_CTL[i], 4'hf, RESP_OKAY);
      sleep_exec   <= 1'b1;
      sleep_active <= 1'b1;
      tick(1);
      sleep_exec     <= 1'b0;
      ref_wake_event <= (i == 2);
      tick(1);
      ref_wake_event <= 1'b0;
      tick(4);
      rd(REG_STAT_ADDR, {27'h0, i == 2, i == 1, 3'h0}, 32'h18,
         RESP_OKAY);
      chk(regulator_sleep_mode, {i == 2, i == 1});
      if (i == 2) begin
        chk(references_on, 1'b0);
        brownout_reset_enable <= 1'b1;
        tick(6);
        chk(references_on, 1'b1);
        brownout_reset_enable <= 1'b0;
      end
      wake_event   <= 1'b1;
      sleep_active <= 1'b0;
      tick(1);
      wake_event <= 1'b0;
      for (n = 0; n < 300 && core_run_enable !== 1'b1; n++) tick(1);
      chk({core_run_enable, n >= REC - 2, core_clk_primary_gate},
          {1'b1, i == 2 || i == 3, i == 3});
      for (n = 0; n < 300 && core_clk_primary_gate !== 1'b1; n++) tick(1);
      tick(2);
      chk(core_clk_primary_gate, 1'b1);
    end
    wrap_up();
  end
endmodule : sleep_power_and_startup_ctrl_bench
